// *** dv/mcu_core_timing_asserts.sv ***
// Cycle-count and state assertions for the accumulator core
`timescale 1ns/10ps
module mcu_core_timing_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] code_rdata,
    input wire logic [7:0] xdata_rdata,
    input wire logic [15:0] code_addr,
    input wire mcu_timing_pkg::xdata_req_t xdata_req,
    input wire mcu_timing_pkg::core_regs_t core_regs,
    input wire logic insn_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [15:0] data_pointer;
    assign data_pointer = {core_regs.data_pointer_high, core_regs.data_pointer_low};
    sequence two_cyc; !insn_done ##1 insn_done; endsequence
    sequence three_cyc; !insn_done [*2] ##1 insn_done; endsequence
    chk_sp_reset: assert property (disable iff (1'b0)
        !rst_n |=> core_regs.sp == 8'h07) else $error("stack pointer reset wrong");
    chk_data_pointer_reset: assert property (disable iff (1'b0)
        !rst_n |=> data_pointer == 16'h0000) else $error("data pointer reset wrong");
    chk_nop_single: assert property (
        insn_done && (code_rdata == 8'h00 || code_rdata == 8'ha5) |=> insn_done)
        else $error("no-operation not one cycle");
    chk_clear_acc: assert property (
        insn_done && code_rdata == 8'he4 |=> insn_done && core_regs.acc == 8'h00)
        else $error("clear accumulator wrong");
    chk_xor_three: assert property (insn_done && code_rdata == 8'h63 |=> three_cyc)
        else $error("xor immediate not three cycles");
    chk_data_pointer_load: assert property (
        insn_done && code_rdata == 8'h90 |=> three_cyc
        ##0 data_pointer == {$past(code_rdata, 2), $past(code_rdata, 1)})
        else $error("data pointer load wrong");
    chk_xdata_write: assert property (
        insn_done && code_rdata == 8'hf0 |=> xdata_req.we && xdata_req.addr == data_pointer
        && xdata_req.wdata == core_regs.acc ##2 insn_done) else $error("external write wrong");
    chk_xdata_read: assert property (
        insn_done && code_rdata == 8'he0 |=> xdata_req.re && xdata_req.addr == data_pointer
        ##1 !xdata_req.re ##1 insn_done) else $error("external read wrong");
    chk_push_order: assert property (
        insn_done && code_rdata == 8'hc0 |=> two_cyc
        ##0 core_regs.sp == $past(core_regs.sp, 2) + 8'h01) else $error("push wrong");
    chk_jz_untaken: assert property (
        insn_done && code_rdata == 8'h60 && core_regs.acc != 8'h00 |=> two_cyc)
        else $error("untaken zero jump not two cycles");
    chk_short_target: assert property (
        insn_done && code_rdata == 8'h80 |-> ##3 insn_done && code_addr == $past(code_addr, 3)
        + 16'h0002 + {{8{$past(code_rdata[7], 2)}}, $past(code_rdata, 2)})
        else $error("short jump target wrong");
    chk_long_target: assert property (
        insn_done && code_rdata == 8'h02 |-> ##4 insn_done
        && code_addr == {$past(code_rdata, 3), $past(code_rdata, 2)})
        else $error("long jump wrong");
endmodule : mcu_core_timing_asserts

bind mcu_core_timing mcu_core_timing_asserts u_chk (.clock(clock), .rst_n(rst_n),
    .code_rdata(code_rdata), .xdata_rdata(xdata_rdata), .code_addr(code_addr),
    .xdata_req(xdata_req), .core_regs(core_regs), .insn_done(insn_done));

// *** dv/mcu_mem_model.sv ***
// Program and external data memory model facing the core
`timescale 1ns/10ps
module mcu_mem_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] code_addr,
    input wire mcu_timing_pkg::xdata_req_t xdata_req,
    output logic [7:0] code_rdata,
    output logic [7:0] xdata_rdata
);
    logic [7:0] rom [256];
    logic [7:0] xram [65536];
    logic [7:0] rd_ff;
    // Code bytes answer in the same cycle
    assign code_rdata = rom[code_addr[7:0]];
    // Read data valid only in the cycle after the strobe, toggles otherwise
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_ff <= 8'h00;
        end else begin
            rd_ff <= xdata_req.re ? xram[xdata_req.addr] : ~rd_ff;
        end
        if (xdata_req.we) begin
            xram[xdata_req.addr] <= xdata_req.wdata;
        end
    end
    assign xdata_rdata = rd_ff;
endmodule : mcu_mem_model

// *** dv/testbench.sv ***
// Program-driven testbench for the accumulator core
`timescale 1ns/10ps
module testbench;
    logic clock;
    logic rst_n;
    logic [7:0] code_rdata;
    logic [7:0] xdata_rdata;
    logic [15:0] code_addr;
    mcu_timing_pkg::xdata_req_t xdata_req;
    mcu_timing_pkg::core_regs_t core_regs;
    logic insn_done;
    int failures;
    int total_checks;
    int n;
    localparam logic [319:0] p0 =
        320'h00a5748123c4901234753_05a6330ff853031e531c0e07831e4e6f0e4e0d08260107002000002_0040;
    localparam logic [215:0] p1 =
        216'hd340020000_e483c2e7d2d37802d8fe_c2d3e8d6b6a102b4360080fe;
    // Per instruction: cycles, accumulator after, next fetch address
    localparam logic [31:0] steps [35] = '{32'h01000002, 32'h02810004, 32'h01030005,
        32'h01300006, 32'h03300009, 32'h0330000c, 32'h0330000f, 32'h03300012, 32'h02a50014,
        32'h02a50016, 32'h02a50018, 32'h01000019, 32'h02a5001a, 32'h03a5001b, 32'h0100001c,
        32'h03a5001d, 32'h02a5001f, 32'h02a50021, 32'h03a50025, 32'h04a50040, 32'h01a50041,
        32'h03a50045, 32'h01000046, 32'h03c20047, 32'h02420049, 32'h0242004b, 32'h0242004d,
        32'h0342004d, 32'h0242004f, 32'h02420051, 32'h01310052, 32'h02350053, 32'h04350056,
        32'h04350059, 32'h03350059};
    mcu_core_timing dut (.clock(clock), .rst_n(rst_n), .code_rdata(code_rdata),
        .xdata_rdata(xdata_rdata), .code_addr(code_addr), .xdata_req(xdata_req),
        .core_regs(core_regs), .insn_done(insn_done));
    mcu_mem_model mem (.clock(clock), .rst_n(rst_n), .code_addr(code_addr),
        .xdata_req(xdata_req), .code_rdata(code_rdata), .xdata_rdata(xdata_rdata));
    task automatic check(input string name, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask : check
    task automatic wait_done(output int c);
        c = 0;
        do begin
            @(negedge clock);
            c++;
        end while (insn_done !== 1'b1 && c < 9);
    endtask : wait_done
    task automatic stop_test();
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #(20 * 400);
        failures++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        failures = 0;
        total_checks = 0;
        for (int a = 0; a < 256; a++) mem.rom[a] = 8'h00;
        for (int a = 0; a < 40; a++) mem.rom[a] = p0[319 - 8 * a -: 8];
        for (int a = 0; a < 27; a++) mem.rom[8'h40 + a] = p1[215 - 8 * a -: 8];
        repeat (16) @(negedge clock);
        check("stack_pointer", 16'h0007, {8'h00, core_regs.sp});
        check("data_pointer", 16'h0000, {core_regs.data_pointer_high, core_regs.data_pointer_low});
        check("accumulator", 16'h0000, {8'h00, core_regs.acc});
        rst_n = 1'b1;
        wait_done(n);
        foreach (steps[i]) begin
            wait_done(n);
            check("cycles", {8'h00, steps[i][31:24]}, 16'(n));
            check("accumulator", {8'h00, steps[i][23:16]}, {8'h00, core_regs.acc});
            check("next_pc", steps[i][15:0], code_addr);
            case (i)
                4: check("data_pointer", 16'h1234, {core_regs.data_pointer_high, core_regs.data_pointer_low});
                9: check("stack_pointer", 16'h0008, {8'h00, core_regs.sp});
                13: check("xdata", 16'h00a5, {8'h00, mem.xram[16'h1234]});
                16: check("popped", 16'h07a5, {core_regs.sp, core_regs.data_pointer_low});
                20: check("carry", 16'h0001, {15'h0000, core_regs.psw[7]});
                25: check("flags", 16'h0088, {8'h00, core_regs.psw});
                28: check("loop_exit", 16'h004f, code_addr);
                29: check("flags", 16'h0080, {8'h00, core_regs.psw});
                32: check("carry", 16'h0000, {15'h0000, core_regs.psw[7]});
                33: check("carry", 16'h0001, {15'h0000, core_regs.psw[7]});
                default: ;
            endcase
        end
        stop_test();
    end
endmodule : testbench

// *** rtl/mcu_core_timing.sv ***
// Cycle-timed accumulator core: decode, operand addressing and execution
`timescale 1ns/10ps
// Behaviour
// - Immediate XOR into direct byte: 3 cycles
// - Single-byte accumulator operations finish in 1 cycle; indirect-RAM forms take 2
// - Moves with indirect RAM take 2 cycles
// - Direct-to-direct move: 3 bytes, 3 cycles
// - Load 16-bit data pointer: 3 bytes, 3 cycles
// - Code memory indexed reads take 3 cycles
// - External data reads and writes take 3 cycles
// - Push and pop take 2 cycles
// - Indirect exchanges 2 cycles; nibble form swaps bits 3:0
// - Carry ops 1 cycle, direct bit ops 2
// - Carry jumps 2/3, bit jumps 3/4, clear-on-set
// - Unconditional jumps 3 cycles, long form 4
// - Accumulator zero tests take 2/3 cycles
// - Compare jumps 4/5 direct/indirect, 3/4 immediate
// - Decrement jumps 2/3 register, 3/4 direct
// - No-operation and opcode 0xA5 take 1 cycle
// - Relative offset signed, from next instruction
// - Direct below 0x80 is RAM, else registers
// - Indirect via register 0/1; bank-relative registers
// - Page jumps stay in 2 kB page; long anywhere
// - Data pointer bytes at 0x82/0x83, reset zero
// - Stack pointer at 0x81, pre-increment, resets 0x07
// - Accumulator at 0xE0, byte and bit addressable
// - Untaken conditional branch one cycle shorter
// - Bank select field picks register bank
module mcu_core_timing (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] code_rdata,
    input wire logic [7:0] xdata_rdata,
    output logic [15:0] code_addr,
    output mcu_timing_pkg::xdata_req_t xdata_req,
    output mcu_timing_pkg::core_regs_t core_regs,
    output logic insn_done
);

    mcu_timing_pkg::core_state_t st_ff;
    mcu_timing_pkg::core_state_t nxt_st;
    mcu_timing_pkg::dec_t dec;
    logic [7:0] iram [0:255];
    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] op, b1, b2, acc, rn, ri, ri_ptr, rn_addr;
    logic [7:0] rd_addr, rd_val, sfr_val, bit_byte, bit_mod, rel, lsrc, dcr;
    logic [7:0] dw_addr, dw_data, iw_addr, iw_data;
    logic [1:0] bank;
    logic [15:0] seq, rel_tgt, new_pc, data_pointer;
    logic exe, finish, ctrue, cy, bit_val, bw, nbit, dw_en, iw_en;
    logic is_call, is_code_memory_read, is_external_data_move, logic_grp;

    function automatic logic [7:0] logic8(input logic [1:0] sel, input logic [7:0] a,
                                          input logic [7:0] b);
        case (sel)
            mcu_timing_pkg::LOP_OR: logic8 = a | b;
            mcu_timing_pkg::LOP_AND: logic8 = a & b;
            default: logic8 = a ^ b;
        endcase
    endfunction : logic8

    // Bytes and base cycle count per opcode; unlisted opcodes take 1 byte and 1 cycle
    function automatic mcu_timing_pkg::dec_t decode(input logic [7:0] o);
        mcu_timing_pkg::dec_t d;
        logic [4:0] lc;
        lc = {2'd1, 3'd1};
        if ((o[7:4] inside {4'h4, 4'h5, 4'h6}) && (o[3:0] >= 4'h2)) begin
            casez (o[3:0])
                4'h2, 4'h4, 4'h5: lc = {2'd2, 3'd2};
                4'h3: lc = {2'd3, 3'd3};
                4'b011?: lc = {2'd1, 3'd2};
                default: lc = {2'd1, 3'd1};
            endcase
        end else begin
            casez (o)
                8'h85, 8'h75, 8'h90, 8'h20, 8'h30, 8'h10, 8'hb4, 8'b1011_1???, 8'hd5:
                    lc = {2'd3, 3'd3};
                8'h02, 8'h12, 8'hb5, 8'b1011_011?: lc = {2'd3, 3'd4};
                8'b????0001, 8'h80: lc = {2'd2, 3'd3};
                8'h93, 8'h83, 8'he0, 8'hf0, 8'b111?001?, 8'h73:
                    lc = {2'd1, 3'd3};
                8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?:
                    lc = {2'd1, 3'd2};
                8'he5, 8'h74, 8'b1010_1???, 8'b0111_1???, 8'hf5, 8'b1000_1???, 8'b1000_011?,
                8'b1010_011?, 8'b0111_011?, 8'hc0, 8'hd0, 8'hc5, 8'hc2, 8'hd2, 8'hb2, 8'h82,
                8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92, 8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
                    lc = {2'd2, 3'd2};
                default: lc = {2'd1, 3'd1};
            endcase
        end
        d.len = lc[4:3];
        d.cyc = lc[2:0];
        d.cond = (o inside {8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'h10, 8'hb4, 8'hb5,
                            8'hd5}) || (o[7:3] == 5'b10111) || (o[7:1] == 7'b1011011)
                 || (o[7:3] == 5'b11011);
        d.bitop = o inside {8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92,
                            8'h20, 8'h30, 8'h10};
        return d;
    endfunction : decode

    always_comb begin
        nxt_st = st_ff;
        nxt_st.xreq.we = 1'b0;
        nxt_st.xreq.re = 1'b0;
        nxt_st.done = 1'b0;
        // Bytes already fetched come from flops, the current one from the code bus
        op = (st_ff.cnt == 3'd0) ? code_rdata : st_ff.ir;
        b1 = (st_ff.cnt == 3'd1) ? code_rdata : st_ff.b1;
        b2 = (st_ff.cnt == 3'd2) ? code_rdata : st_ff.b2;
        dec = decode(op);
        acc = st_ff.regs.acc;
        cy = st_ff.regs.psw[mcu_timing_pkg::PSW_CY];
        data_pointer = {st_ff.regs.data_pointer_high, st_ff.regs.data_pointer_low};
        bank = st_ff.regs.psw[mcu_timing_pkg::PSW_RS_HI:mcu_timing_pkg::PSW_RS_LO];
        rn_addr = {3'b000, bank, op[2:0]};
        rn = iram[rn_addr];
        ri_ptr = iram[{3'b000, bank, 2'b00, op[0]}];
        ri = iram[ri_ptr];
        bit_byte = b1[7] ? {b1[7:3], 3'b000} : {mcu_timing_pkg::BIT_AREA_HI, b1[6:3]};
        rd_addr = dec.bitop ? bit_byte : b1;
        case (rd_addr)
            mcu_timing_pkg::SFR_SP: sfr_val = st_ff.regs.sp;
            mcu_timing_pkg::SFR_DPL: sfr_val = st_ff.regs.data_pointer_low;
            mcu_timing_pkg::SFR_DPH: sfr_val = st_ff.regs.data_pointer_high;
            mcu_timing_pkg::SFR_PSW: sfr_val = {st_ff.regs.psw[7:1], ^acc};
            mcu_timing_pkg::SFR_ACC: sfr_val = acc;
            default: sfr_val = 8'h00;
        endcase
        rd_val = rd_addr[7] ? sfr_val : iram[rd_addr];
        bit_val = rd_val[b1[2:0]];
        seq = st_ff.pc + {14'd0, dec.len};
        rel = (dec.len == 2'd3) ? b2 : b1;
        rel_tgt = seq + {{8{rel[7]}}, rel};
        is_call = (op[4:0] == 5'b10001) || (op == 8'h12);
        is_code_memory_read = (op == 8'h93) || (op == 8'h83);
        is_external_data_move = (op[7:5] == 3'b111) && ((op[3:0] == 4'h0) || (op[3:1] == 3'b001));
        logic_grp = (op[7:4] inside {4'h4, 4'h5, 4'h6}) && (op[3:0] >= 4'h2);
        lsrc = op[3] ? rn : ((op[2:1] == 2'b11) ? ri : (op[0] ? rd_val : b1));
        exe = (st_ff.cnt == dec.cyc - 3'd1);
        ctrue = 1'b0;
        bw = 1'b0;
        nbit = 1'b0;
        dcr = 8'h00;
        dw_en = 1'b0;
        dw_addr = 8'h00;
        dw_data = 8'h00;
        iw_en = 1'b0;
        iw_addr = 8'h00;
        iw_data = 8'h00;
        new_pc = seq;
        finish = 1'b0;
        // Calls push the return low byte one cycle before the high byte
        if (is_call && (st_ff.cnt == dec.cyc - 3'd2)) begin
            nxt_st.regs.sp = st_ff.regs.sp + 8'd1;
            iw_en = 1'b1;
            iw_addr = st_ff.regs.sp + 8'd1;
            iw_data = seq[7:0];
        end
        // External strobe goes out in the cycle after the opcode
        if (is_external_data_move && (st_ff.cnt == 3'd0)) begin
            nxt_st.xreq.addr = op[1] ? {mcu_timing_pkg::XDATA_PAGE, ri_ptr} : data_pointer;
            nxt_st.xreq.wdata = acc;
            nxt_st.xreq.we = op[4];
            nxt_st.xreq.re = ~op[4];
        end
        if (st_ff.taken && (st_ff.cnt == dec.cyc)) begin
            finish = 1'b1;
            new_pc = rel_tgt;
        end else if (exe) begin
            if (logic_grp) begin
                if (op[3:1] == 3'b001) begin
                    dw_en = 1'b1;
                    dw_addr = b1;
                    dw_data = logic8(op[5:4], rd_val, op[0] ? b2 : acc);
                end else begin
                    nxt_st.regs.acc = logic8(op[5:4], acc, lsrc);
                end
            end else begin
                casez (op)
                    8'he4: nxt_st.regs.acc = 8'h00;
                    8'hf4: nxt_st.regs.acc = ~acc;
                    8'h23: nxt_st.regs.acc = {acc[6:0], acc[7]};
                    8'h33: begin
                        nxt_st.regs.acc = {acc[6:0], cy};
                        nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = acc[7];
                    end
                    8'h03: nxt_st.regs.acc = {acc[0], acc[7:1]};
                    8'h13: begin
                        nxt_st.regs.acc = {cy, acc[7:1]};
                        nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = acc[0];
                    end
                    8'hc4: nxt_st.regs.acc = {acc[3:0], acc[7:4]};
                    8'b1110_1???: nxt_st.regs.acc = rn;
                    8'he5: nxt_st.regs.acc = rd_val;
                    8'b1110_011?: nxt_st.regs.acc = ri;
                    8'h74: nxt_st.regs.acc = b1;
                    8'b1111_1???, 8'b1010_1???, 8'b0111_1???: begin
                        iw_en = 1'b1;
                        iw_addr = rn_addr;
                        iw_data = op[7] ? (op[6] ? acc : rd_val) : b1;
                    end
                    8'hf5, 8'b1000_1???, 8'b1000_011?, 8'h75: begin
                        dw_en = 1'b1;
                        dw_addr = b1;
                        dw_data = op[7] ? (op[6] ? acc : (op[3] ? rn : ri)) : b2;
                    end
                    8'h85: begin
                        dw_en = 1'b1;
                        dw_addr = b2;
                        dw_data = rd_val;
                    end
                    8'b1111_011?, 8'b1010_011?, 8'b0111_011?: begin
                        iw_en = 1'b1;
                        iw_addr = ri_ptr;
                        iw_data = op[7] ? (op[6] ? acc : rd_val) : b1;
                    end
                    8'h90: begin
                        nxt_st.regs.data_pointer_high = b1;
                        nxt_st.regs.data_pointer_low = b2;
                    end
                    8'h93, 8'h83: nxt_st.regs.acc = b1;
                    8'he0, 8'b1110001?: nxt_st.regs.acc = xdata_rdata;
                    8'hc0: begin
                        nxt_st.regs.sp = st_ff.regs.sp + 8'd1;
                        iw_en = 1'b1;
                        iw_addr = st_ff.regs.sp + 8'd1;
                        iw_data = rd_val;
                    end
                    8'hd0: begin
                        nxt_st.regs.sp = st_ff.regs.sp - 8'd1;
                        dw_en = 1'b1;
                        dw_addr = b1;
                        dw_data = iram[st_ff.regs.sp];
                    end
                    8'b1100_1???: begin
                        nxt_st.regs.acc = rn;
                        iw_en = 1'b1;
                        iw_addr = rn_addr;
                        iw_data = acc;
                    end
                    8'hc5: begin
                        nxt_st.regs.acc = rd_val;
                        dw_en = 1'b1;
                        dw_addr = b1;
                        dw_data = acc;
                    end
                    8'b1100_011?: begin
                        nxt_st.regs.acc = ri;
                        iw_en = 1'b1;
                        iw_addr = ri_ptr;
                        iw_data = acc;
                    end
                    8'b1101_011?: begin
                        nxt_st.regs.acc = {acc[7:4], ri[3:0]};
                        iw_en = 1'b1;
                        iw_addr = ri_ptr;
                        iw_data = {ri[7:4], acc[3:0]};
                    end
                    8'hc3: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = 1'b0;
                    8'hd3: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = 1'b1;
                    8'hb3: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = ~cy;
                    8'hc2, 8'hd2, 8'hb2, 8'h92: begin
                        bw = 1'b1;
                        nbit = (op == 8'hb2) ? ~bit_val : ((op == 8'h92) ? cy : op[4]);
                    end
                    8'h82: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = cy & bit_val;
                    8'hb0: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = cy & ~bit_val;
                    8'h72: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = cy | bit_val;
                    8'ha0: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = cy | ~bit_val;
                    8'ha2: nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] = bit_val;
                    8'h40: ctrue = cy;
                    8'h50: ctrue = ~cy;
                    8'h20: ctrue = bit_val;
                    8'h30: ctrue = ~bit_val;
                    8'h10: begin
                        ctrue = bit_val;
                        bw = bit_val;
                    end
                    8'h60: ctrue = (acc == 8'h00);
                    8'h70: ctrue = (acc != 8'h00);
                    8'hb4, 8'hb5, 8'b1011_011?, 8'b1011_1???: begin
                        dcr = (op == 8'hb4) ? acc : ((op == 8'hb5) ? acc : (op[3] ? rn : ri));
                        ctrue = (dcr != ((op == 8'hb5) ? rd_val : b1));
                        nxt_st.regs.psw[mcu_timing_pkg::PSW_CY] =
                            (dcr < ((op == 8'hb5) ? rd_val : b1));
                    end
                    8'b1101_1???: begin
                        iw_en = 1'b1;
                        iw_addr = rn_addr;
                        iw_data = rn - 8'd1;
                        ctrue = (rn != 8'd1);
                    end
                    8'hd5: begin
                        dw_en = 1'b1;
                        dw_addr = b1;
                        dw_data = rd_val - 8'd1;
                        ctrue = (rd_val != 8'd1);
                    end
                    8'b????0001: begin
                        new_pc = {seq[15:11], op[7:5], b1};
                        if (op[4]) begin
                            nxt_st.regs.sp = st_ff.regs.sp + 8'd1;
                            iw_en = 1'b1;
                            iw_addr = st_ff.regs.sp + 8'd1;
                            iw_data = seq[15:8];
                        end
                    end
                    8'h02, 8'h12: begin
                        new_pc = {b1, b2};
                        if (op[4]) begin
                            nxt_st.regs.sp = st_ff.regs.sp + 8'd1;
                            iw_en = 1'b1;
                            iw_addr = st_ff.regs.sp + 8'd1;
                            iw_data = seq[15:8];
                        end
                    end
                    8'h80: new_pc = rel_tgt;
                    8'h73: new_pc = data_pointer + {8'h00, acc};
                    default: ;
                endcase
            end
            finish = !(dec.cond && ctrue);
            nxt_st.taken = dec.cond && ctrue;
        end
        bit_mod = rd_val;
        bit_mod[b1[2:0]] = nbit;
        if (bw) begin
            dw_en = 1'b1;
            dw_addr = bit_byte;
            dw_data = bit_mod;
        end
        // Register-space writes win over any core update made above
        if (dw_en && dw_addr[7]) begin
            case (dw_addr)
                mcu_timing_pkg::SFR_SP: nxt_st.regs.sp = dw_data;
                mcu_timing_pkg::SFR_DPL: nxt_st.regs.data_pointer_low = dw_data;
                mcu_timing_pkg::SFR_DPH: nxt_st.regs.data_pointer_high = dw_data;
                mcu_timing_pkg::SFR_PSW: nxt_st.regs.psw = dw_data;
                mcu_timing_pkg::SFR_ACC: nxt_st.regs.acc = dw_data;
                default: ;
            endcase
        end
        mem_we = iw_en || (dw_en && !dw_addr[7]);
        mem_wa = iw_en ? iw_addr : dw_addr;
        mem_wd = iw_en ? iw_data : dw_data;
        if (st_ff.cnt == 3'd0) begin
            nxt_st.ir = code_rdata;
        end
        if (st_ff.cnt == 3'd1) begin
            nxt_st.b1 = code_rdata;
        end
        if (st_ff.cnt == 3'd2) begin
            nxt_st.b2 = code_rdata;
        end
        if (finish) begin
            nxt_st.pc = new_pc;
            nxt_st.fetch = new_pc;
            nxt_st.cnt = 3'd0;
            nxt_st.taken = 1'b0;
            nxt_st.done = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 3'd1;
            nxt_st.fetch = st_ff.fetch + 16'd1;
            if (is_code_memory_read && (st_ff.cnt == 3'd0)) begin
                nxt_st.fetch = {8'h00, acc} + (op[4] ? data_pointer : seq);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst_n && mem_we) begin
            iram[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff <= mcu_timing_pkg::STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign code_addr = st_ff.fetch;
    assign xdata_req = st_ff.xreq;
    assign core_regs = st_ff.regs;
    assign insn_done = st_ff.done;

endmodule : mcu_core_timing

// *** rtl/mcu_timing_pkg.sv ***
// Shared constants and carrier types for the cycle-timed accumulator core
package mcu_timing_pkg;

    // Special-function register addresses
    localparam logic [7:0] SFR_SP = 8'h81;
    localparam logic [7:0] SFR_DPL = 8'h82;
    localparam logic [7:0] SFR_DPH = 8'h83;
    localparam logic [7:0] SFR_PSW = 8'hd0;
    localparam logic [7:0] SFR_ACC = 8'he0;

    // Reset values
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Flag word field positions
    localparam int PSW_CY = 7;
    localparam int PSW_RS_HI = 4;
    localparam int PSW_RS_LO = 3;

    // Bit-addressable RAM area starts at byte 0x20
    localparam logic [3:0] BIT_AREA_HI = 4'h2;

    // Upper address byte used by the 8-bit external data forms
    localparam logic [7:0] XDATA_PAGE = 8'h00;

    // Logic group operation select (opcode bits 5:4)
    localparam logic [1:0] LOP_OR = 2'b00;
    localparam logic [1:0] LOP_AND = 2'b01;

    // Length in bytes, base cycle count, conditional, bit operand
    typedef struct packed {
        logic [1:0] len;
        logic [2:0] cyc;
        logic cond;
        logic bitop;
    } dec_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } xdata_req_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] sp;
        logic [7:0] data_pointer_low;
        logic [7:0] data_pointer_high;
        logic [7:0] psw;
    } core_regs_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] fetch;
        logic [2:0] cnt;
        logic [7:0] ir;
        logic [7:0] b1;
        logic [7:0] b2;
        logic taken;
        core_regs_t regs;
        xdata_req_t xreq;
        logic done;
    } core_state_t;

    localparam core_regs_t REGS_RESET = '{acc: 8'h00, sp: SP_RESET, data_pointer_low: 8'h00, data_pointer_high: 8'h00,
                                          psw: 8'h00};
    localparam core_state_t STATE_RESET = '{pc: PC_RESET, fetch: PC_RESET, cnt: 3'd0,
                                            ir: 8'h00, b1: 8'h00, b2: 8'h00, taken: 1'b0,
                                            regs: REGS_RESET, xreq: '0, done: 1'b0};

endpackage : mcu_timing_pkg
